/* inc/gpc_pkg.sv */
// gpc_pkg: shared constants and types for the port C/D/E block.
// assumes an 8-bit register port with byte-wide offsets.
`default_nettype none
package gpc_pkg;

  // register offsets
  localparam logic [7:0] GPC_ADDR_PORT_C_DATA = 8'h07;
  localparam logic [7:0] GPC_ADDR_PORT_D_DATA = 8'h08;
  localparam logic [7:0] GPC_ADDR_PORT_E_DATA = 8'h09;
  localparam logic [7:0] GPC_ADDR_PORT_C_DIR  = 8'h87;
  localparam logic [7:0] GPC_ADDR_PORT_D_DIR  = 8'h88;
  localparam logic [7:0] GPC_ADDR_PORT_E_DIR  = 8'h89;
  localparam logic [7:0] GPC_ADDR_ANALOG_CFG  = 8'h9f;

  // field positions in port_e_direction_slave_status
  localparam int GPC_BIT_IN_FULL  = 7;
  localparam int GPC_BIT_OUT_FULL = 6;
  localparam int GPC_BIT_OVERFLOW = 5;
  localparam int GPC_BIT_MODE     = 4;

  // reset values
  localparam logic [7:0] GPC_DIR_RST      = 8'hff;
  localparam logic [2:0] GPC_E_DIR_RST    = 3'h7;
  localparam logic [7:0] GPC_ANALOG_RST   = 8'h00;
  localparam logic [7:0] GPC_LATCH8_RST   = 8'h00;
  localparam logic [2:0] GPC_LATCH3_RST   = 3'h0;
  // analog_select_field at or above this makes RE2:RE0 digital
  localparam logic [3:0] GPC_SEL_DIGITAL_MIN = 4'h6;

  typedef enum logic [2:0] {
    GPC_PSP_IDLE  = 3'b001,
    GPC_PSP_WRITE = 3'b010,
    GPC_PSP_READ  = 3'b100
  } gpc_psp_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpc_bus_req_s;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } gpc_pins8_s;

  typedef struct packed {
    logic [2:0] level;
    logic [2:0] enable;
  } gpc_pins3_s;

  typedef struct packed {
    logic [7:0] c_latch;
    logic [7:0] d_latch;
    logic [2:0] e_latch;
    logic [7:0] c_dir;
    logic [7:0] d_dir;
    logic [2:0] e_dir;
    logic [7:0] analog_cfg;
    logic       mode;
    logic       input_full_flag;
    logic       output_full_flag;
    logic       input_overflow_flag;
    logic [7:0] in_latch;
    gpc_psp_e   psp;
    logic [7:0] rdata;
    gpc_pins8_s pc_drive;
    gpc_pins8_s pd_drive;
    gpc_pins3_s pe_drive;
    logic       irq;
  } gpc_state_s;

endpackage : gpc_pkg
`default_nettype wire

/* rtl/gpc_sync.sv */
// gpc_sync: two-flop synchroniser for asynchronous pin levels.
// assumes the caller reads only the second stage.
`timescale 1ns/1ps
`default_nettype none
module gpc_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // levels
  input  wire logic [W-1:0] async_level,
  output logic      [W-1:0] sync_level
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1     <= '1;
      sync_level <= '1;
    end
    else
    begin
      stage1     <= async_level;
      sync_level <= stage1;
    end
  end

endmodule : gpc_sync
`default_nettype wire

/* rtl/gpc_port_c_mux.sv */
// gpc_port_c_mux: per-pin choice between port latch and peripheral.
// assumes peripheral controls arrive on the core clock.
`timescale 1ns/1ps
`default_nettype none
module gpc_port_c_mux (
  // port state
  input  wire logic [7:0] latch,
  input  wire logic [7:0] dir,
  // peripheral side
  input  wire logic [7:0] periph_sel,
  input  wire logic [7:0] periph_data,
  input  wire logic [7:0] periph_oe,
  // driver
  output logic      [7:0] drive,
  output logic      [7:0] drive_en
);

  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    // [RULE1] data select
    assign drive[i]    = periph_sel[i] ? periph_data[i] : latch[i];
    // [RULE2] peripheral enable only when selected, else direction bit
    assign drive_en[i] = periph_sel[i] ? periph_oe[i] : ~dir[i];
  end

endmodule : gpc_port_c_mux
`default_nettype wire

/* rtl/gpc_ports.sv */
// gpc_ports: general I/O ports C, D and E with the parallel slave port.
// assumes resetn is power-on reset, sys_reset any other reset.
//
// Contract
// [RULE1] each port C pin drives latch or peripheral output per select
// [RULE2] peripheral enable counts only while selected, else direction bit
// [RULE3] port D has eight pins, each set input or output by direction
// [RULE4] mode bit 4 of port E direction turns port D into slave port
// [RULE5] software makes strobe pins digital inputs before slave mode
// [RULE6] port E pins in analog use read back as zero
// [RULE7] port E direction bits keep driving pins during analog use
// [RULE8] power-on reset puts all port E pins in analog mode
// [RULE9] bit 7 set while externally written byte awaits CPU read
// [RULE10] bit 6 set while CPU byte not yet read externally
// [RULE11] bit 5 set on write over unread byte, cleared by software
// [RULE12] bit 4 selects slave port mode, resets to zero
// [RULE13] bit 3 reads as zero
// [RULE14] bits 2..0 set chip-select, write, read pin direction, reset one
// [RULE15] external read strobe low reads port D only while selected
// [RULE16] external write strobe low writes port D only while selected
// [RULE17] chip select is active low
// [RULE18] write end sets input-full and interrupt flag together
// [RULE19] input-full clears only on software read of port D
// [RULE20] output-full clears when select and read seen low, until rewrite
// [RULE21] outside slave mode full flags held clear, overflow kept
// [RULE22] directions reset to inputs, data latches survive soft resets
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module gpc_ports
  import gpc_pkg::*;
(
  // clock and resets
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         sys_reset,
  // register port
  input  wire gpc_bus_req_s bus_req,
  output logic      [7:0]   bus_rdata,
  // port C
  input  wire logic [7:0]   pc_level,
  output gpc_pins8_s        pc_drive,
  input  wire logic [7:0]   periph_sel,
  input  wire logic [7:0]   periph_data,
  input  wire logic [7:0]   periph_oe,
  // port D
  input  wire logic [7:0]   pd_level,
  output gpc_pins8_s        pd_drive,
  // port E
  input  wire logic [2:0]   pe_level,
  output gpc_pins3_s        pe_drive,
  // slave port event
  output logic              slave_port_irq_flag
);

  localparam gpc_state_s RESET_STATE = '{
    c_latch:             GPC_LATCH8_RST,
    d_latch:             GPC_LATCH8_RST,
    e_latch:             GPC_LATCH3_RST,
    c_dir:               GPC_DIR_RST,
    d_dir:               GPC_DIR_RST,
    e_dir:               GPC_E_DIR_RST,
    analog_cfg:          GPC_ANALOG_RST,
    mode:                1'b0,
    input_full_flag:     1'b0,
    output_full_flag:    1'b0,
    input_overflow_flag: 1'b0,
    in_latch:            GPC_LATCH8_RST,
    psp:                 GPC_PSP_IDLE,
    rdata:               8'h00,
    pc_drive:            '0,
    pd_drive:            '0,
    pe_drive:            '0,
    irq:                 1'b0
  };

  gpc_state_s s;
  gpc_state_s next_s;

  logic [7:0] pc_sync;
  logic [7:0] pd_sync;
  logic [2:0] pe_sync;
  logic [7:0] pc_mux_level;
  logic [7:0] pc_mux_en;

  gpc_sync #(.W(8)) u_sync_c (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .async_level(pc_level),
    .sync_level (pc_sync)
  );

  gpc_sync #(.W(8)) u_sync_d (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .async_level(pd_level),
    .sync_level (pd_sync)
  );

  gpc_sync #(.W(3)) u_sync_e (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .async_level(pe_level),
    .sync_level (pe_sync)
  );

  gpc_port_c_mux u_mux_c (
    .latch      (s.c_latch),
    .dir        (s.c_dir),
    .periph_sel (periph_sel),
    .periph_data(periph_data),
    .periph_oe  (periph_oe),
    .drive      (pc_mux_level),
    .drive_en   (pc_mux_en)
  );

  // true while the port E pins are analog inputs
  function automatic logic is_analog(input logic [7:0] cfg);
    is_analog = (cfg[3:0] < GPC_SEL_DIGITAL_MIN);
  endfunction : is_analog

  logic cs_act;
  logic wr_act;
  logic rd_act;

  // strobes are seen through the synchronisers, so the host must hold
  // each strobe level for more than one clock or it may be missed
  // [RULE17] active-low select
  assign cs_act = s.mode & ~pe_sync[2];
  // [RULE16] write gated by select
  assign wr_act = cs_act & ~pe_sync[1];
  // [RULE15] read gated by select
  assign rd_act = cs_act & ~pe_sync[0];

  always_comb
  begin
    next_s     = s;
    next_s.irq = 1'b0;

    // register reads, data one cycle later
    if (bus_req.rd)
    begin
      if (bus_req.addr == GPC_ADDR_PORT_C_DATA)
      begin
        next_s.rdata = pc_sync;
      end
      else if (bus_req.addr == GPC_ADDR_PORT_D_DATA)
      begin
        next_s.rdata = s.mode ? s.in_latch : pd_sync;
        // [RULE19] cpu read empties input
        next_s.input_full_flag = 1'b0;
      end
      else if (bus_req.addr == GPC_ADDR_PORT_E_DATA)
      begin
        // [RULE6] analog pins read zero
        next_s.rdata = {5'h00, is_analog(s.analog_cfg) ? 3'h0 : pe_sync};
      end
      else if (bus_req.addr == GPC_ADDR_PORT_C_DIR)
      begin
        next_s.rdata = s.c_dir;
      end
      else if (bus_req.addr == GPC_ADDR_PORT_D_DIR)
      begin
        next_s.rdata = s.d_dir;
      end
      else if (bus_req.addr == GPC_ADDR_PORT_E_DIR)
      begin
        // [RULE9] [RULE10] [RULE13] status and zero bit 3
        next_s.rdata = {s.input_full_flag, s.output_full_flag,
                        s.input_overflow_flag, s.mode, 1'b0, s.e_dir};
      end
      else if (bus_req.addr == GPC_ADDR_ANALOG_CFG)
      begin
        next_s.rdata = s.analog_cfg;
      end
      else
      begin
        next_s.rdata = 8'h00;
      end
    end

    // register writes
    if (bus_req.wr)
    begin
      if (bus_req.addr == GPC_ADDR_PORT_C_DATA)
      begin
        next_s.c_latch = bus_req.wdata;
      end
      else if (bus_req.addr == GPC_ADDR_PORT_E_DATA)
      begin
        next_s.e_latch = bus_req.wdata[2:0];
      end
      else if (bus_req.addr == GPC_ADDR_PORT_C_DIR)
      begin
        next_s.c_dir = bus_req.wdata;
      end
      else if (bus_req.addr == GPC_ADDR_PORT_D_DIR)
      begin
        // [RULE3] per-pin direction
        next_s.d_dir = bus_req.wdata;
      end
      else if (bus_req.addr == GPC_ADDR_PORT_E_DIR)
      begin
        // [RULE12] mode select
        next_s.mode = bus_req.wdata[GPC_BIT_MODE];
        // [RULE14] strobe pin directions
        next_s.e_dir = bus_req.wdata[2:0];
        // [RULE11] software-only clear
        if (!bus_req.wdata[GPC_BIT_OVERFLOW])
        begin
          next_s.input_overflow_flag = 1'b0;
        end
      end
      else if (bus_req.addr == GPC_ADDR_ANALOG_CFG)
      begin
        next_s.analog_cfg = bus_req.wdata;
      end
    end

    // slave port transfer tracking; set after clears so the set wins
    case (s.psp)
      GPC_PSP_IDLE:
      begin
        if (wr_act)
        begin
          next_s.psp      = GPC_PSP_WRITE;
          next_s.in_latch = pd_sync;
          // [RULE11] overflow on unread byte
          if (s.input_full_flag)
          begin
            next_s.input_overflow_flag = 1'b1;
          end
        end
        else if (rd_act)
        begin
          next_s.psp = GPC_PSP_READ;
          // [RULE20] cleared at read start
          next_s.output_full_flag = 1'b0;
        end
      end
      GPC_PSP_WRITE:
      begin
        if (wr_act)
        begin
          // keep sampling; last value before release is kept
          next_s.in_latch = pd_sync;
        end
        else
        begin
          // [RULE18] full and irq together
          next_s.psp             = GPC_PSP_IDLE;
          next_s.input_full_flag = 1'b1;
          next_s.irq             = 1'b1;
        end
      end
      GPC_PSP_READ:
      begin
        if (!rd_act)
        begin
          // read done: event only, output buffer was emptied at start
          next_s.psp = GPC_PSP_IDLE;
          next_s.irq = 1'b1;
        end
      end
      default:
      begin
        next_s.psp = GPC_PSP_IDLE;
      end
    endcase

    // cpu write of port D refills the output buffer and wins a tie
    if (bus_req.wr && bus_req.addr == GPC_ADDR_PORT_D_DATA)
    begin
      next_s.d_latch = bus_req.wdata;
      // [RULE10] buffer holds an unread byte
      if (s.mode)
      begin
        next_s.output_full_flag = 1'b1;
      end
    end

    // [RULE21] full flags held clear outside slave mode
    if (!next_s.mode)
    begin
      next_s.input_full_flag  = 1'b0;
      next_s.output_full_flag = 1'b0;
      next_s.psp              = GPC_PSP_IDLE;
    end

    // [RULE22] soft reset keeps latches
    if (sys_reset)
    begin
      next_s.c_dir               = GPC_DIR_RST;
      next_s.d_dir               = GPC_DIR_RST;
      next_s.e_dir               = GPC_E_DIR_RST;
      next_s.analog_cfg          = GPC_ANALOG_RST;
      next_s.mode                = 1'b0;
      next_s.input_full_flag     = 1'b0;
      next_s.output_full_flag    = 1'b0;
      next_s.input_overflow_flag = 1'b0;
      next_s.psp                 = GPC_PSP_IDLE;
      next_s.irq                 = 1'b0;
    end

    // pin drivers, registered so outputs come from flops
    next_s.pc_drive.level  = pc_mux_level;
    next_s.pc_drive.enable = pc_mux_en;
    next_s.pd_drive.level  = next_s.d_latch;
    // [RULE4] slave mode ignores port D direction
    if (next_s.mode)
    begin
      next_s.pd_drive.enable = {8{rd_act}};
    end
    else
    begin
      // [RULE3] per-pin output enable
      next_s.pd_drive.enable = ~next_s.d_dir;
    end
    next_s.pe_drive.level  = next_s.e_latch;
    // [RULE7] direction still drives analog pins
    next_s.pe_drive.enable = ~next_s.e_dir;
  end

  // [RULE8] power-on sets analog config to all-analog
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= RESET_STATE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign bus_rdata           = s.rdata;
  assign pc_drive            = s.pc_drive;
  assign pd_drive            = s.pd_drive;
  assign pe_drive            = s.pe_drive;
  assign slave_port_irq_flag = s.irq;

endmodule : gpc_ports
`default_nettype wire

/* sim/gpc_ports_assertions.sv */
// gpc_ports_assertions: port-level checks for the port C/D/E block.
// assumes it is bound onto gpc_ports and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module gpc_ports_assertions
  import gpc_pkg::*;
(
  // clock and resets
  input wire logic         clk_sys,
  input wire logic         resetn,
  input wire logic         sys_reset,
  // register port
  input wire gpc_bus_req_s bus_req,
  input wire logic [7:0]   bus_rdata,
  // pins
  input wire logic [7:0]   pc_level,
  input wire gpc_pins8_s   pc_drive,
  input wire logic [7:0]   periph_sel,
  input wire logic [7:0]   periph_data,
  input wire logic [7:0]   periph_oe,
  input wire logic [7:0]   pd_level,
  input wire gpc_pins8_s   pd_drive,
  input wire logic [2:0]   pe_level,
  input wire gpc_pins3_s   pe_drive,
  input wire logic         slave_port_irq_flag
);
  logic       live;
  logic       mode_q;
  logic [3:0] ana_q;
  logic [3:0] since;
  wire        strobe_on = !pe_level[2] && !(pe_level[1] && pe_level[0]);
  wire        rd_only   = !pe_level[2] && !pe_level[0] && pe_level[1];

  // mirror of mode and analog select; live guards one-cycle-late checks
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      live   <= 1'b0;
      mode_q <= 1'b0;
      ana_q  <= 4'h0;
      since  <= 4'hf;
    end
    else
    begin
      live  <= !sys_reset;
      since <= strobe_on ? 4'h0 : ((since == 4'hf) ? since : since + 4'h1);
      if (sys_reset)
      begin
        mode_q <= 1'b0;
        ana_q  <= 4'h0;
      end
      else if (bus_req.wr && bus_req.addr == GPC_ADDR_PORT_E_DIR)
        mode_q <= bus_req.wdata[GPC_BIT_MODE];
      else if (bus_req.wr && bus_req.addr == GPC_ADDR_ANALOG_CFG)
        ana_q <= bus_req.wdata[3:0];
    end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_c_level_select:
    assert property (live |-> ((pc_drive.level ^ $past(periph_data)) & $past(periph_sel)) == 8'h00)
    else $error("port C level ignores peripheral data");
  a_c_enable_select:
    assert property (live |-> ((pc_drive.enable ^ $past(periph_oe)) & $past(periph_sel)) == 8'h00)
    else $error("port C enable ignores peripheral enable");
  a_irq_one_pulse:
    assert property (slave_port_irq_flag |=> !slave_port_irq_flag)
    else $error("slave port event longer than one cycle");
  a_irq_needs_select:
    assert property (slave_port_irq_flag |-> since <= 4'h8)
    else $error("slave port event without selected strobe");
  a_irq_needs_mode:
    assert property (slave_port_irq_flag |-> mode_q)
    else $error("slave port event outside slave mode");
  a_reset_quiet:
    assert property (!$past(resetn) |=> pd_drive.enable == 8'h00 && pe_drive.enable == 3'h0)
    else $error("port D or E driving after power-on reset");
  a_e_analog_zero:
    assert property (bus_req.rd && bus_req.addr == GPC_ADDR_PORT_E_DATA |=>
      bus_rdata[7:3] == 5'h0 && (ana_q >= GPC_SEL_DIGITAL_MIN || bus_rdata[2:0] == 3'h0))
    else $error("port E data read not zero where expected");
  a_status_bit3:
    assert property (bus_req.rd && bus_req.addr == GPC_ADDR_PORT_E_DIR |=> !bus_rdata[3])
    else $error("unused status bit reads one");
  a_slave_read_drive:
    assert property ((mode_q && ana_q >= GPC_SEL_DIGITAL_MIN && rd_only)[*6] |->
      pd_drive.enable == 8'hff)
    else $error("port D not driven during external read");

  c_ext_event: cover property (slave_port_irq_flag);
  c_slave_drive: cover property (mode_q && pd_drive.enable == 8'hff);
  c_periph_sel: cover property (live && (periph_sel & periph_oe) != 8'h00);
endmodule : gpc_ports_assertions

bind gpc_ports gpc_ports_assertions i_gpc_ports_assertions (
  .clk_sys(clk_sys), .resetn(resetn), .sys_reset(sys_reset), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .pc_level(pc_level), .pc_drive(pc_drive),
  .periph_sel(periph_sel), .periph_data(periph_data), .periph_oe(periph_oe),
  .pd_level(pd_level), .pd_drive(pd_drive), .pe_level(pe_level), .pe_drive(pe_drive),
  .slave_port_irq_flag(slave_port_irq_flag));
`default_nettype wire

/* sim/gpc_psp_host.sv */
// gpc_psp_host: external 8-bit processor on the slave port pins.
// assumes port E pins are the strobes; resolves port D and E wires.
`timescale 1ns/1ps
`default_nettype none
module gpc_psp_host
  import gpc_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // device drivers
  input  wire gpc_pins8_s pd_drive,
  input  wire gpc_pins3_s pe_drive,
  // resolved pins
  output logic      [7:0] pd_level,
  output logic      [2:0] pe_level
);
  logic [7:0] data;
  logic       drv;
  logic [2:0] strobe_n;
  logic [7:0] last;

  initial
  begin
    data     = 8'h00;
    drv      = 1'b0;
    strobe_n = 3'h7;
    last     = 8'h00;
  end

  // released bus flips each cycle so stale data never passes
  always @(posedge clk_sys)
    last <= pd_level;
  assign pd_level = (pd_drive.enable & pd_drive.level) |
                    (~pd_drive.enable & (drv ? data : ~last));
  assign pe_level = (pe_drive.enable & pe_drive.level) | (~pe_drive.enable & strobe_n);

  task automatic xfer(input logic [2:0] s, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    data     <= d;
    drv      <= !s[1];
    strobe_n <= s;
    repeat (8) @(posedge clk_sys);
    q = pd_level;
    strobe_n <= 3'h7;
    @(posedge clk_sys);
    drv <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : xfer
endmodule : gpc_psp_host
`default_nettype wire

/* sim/test_gpc_ports.sv */
// test_gpc_ports: self-checking bench for the port C/D/E block.
// assumes gpc_psp_host plays the external processor.
`timescale 1ns/1ps
`default_nettype none
module test_gpc_ports;
  import gpc_pkg::*;
  logic clk_sys, resetn, sys_reset, irq;
  gpc_bus_req_s bus_req;
  logic [7:0] bus_rdata, pc_level, pd_level, periph_sel, periph_data, periph_oe, v;
  logic [2:0] pe_level;
  gpc_pins8_s pc_drive, pd_drive;
  gpc_pins3_s pe_drive;
  int err_count = 0, comparisons = 0, cycles = 0, irq_n = 0;
  logic [7:0] rows [12][3] = '{'{8'h87, 8'h5a, 8'h5a}, '{8'h88, 8'h3c, 8'h3c},
    '{8'h89, 8'he3, 8'h03}, '{8'h9f, 8'ha5, 8'ha5}, '{8'h09, 8'h02, 8'h00},
    '{8'h9f, 8'h06, 8'h06}, '{8'h09, 8'h02, 8'h03}, '{8'h30, 8'h77, 8'h00},
    '{8'h87, 8'h00, 8'h00}, '{8'h07, 8'h96, 8'h96}, '{8'h88, 8'h00, 8'h00},
    '{8'h08, 8'hc3, 8'hc3}};

  gpc_ports i_gpc_ports (.clk_sys(clk_sys), .resetn(resetn), .sys_reset(sys_reset),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .pc_level(pc_level), .pc_drive(pc_drive),
    .periph_sel(periph_sel), .periph_data(periph_data), .periph_oe(periph_oe),
    .pd_level(pd_level), .pd_drive(pd_drive), .pe_level(pe_level), .pe_drive(pe_drive),
    .slave_port_irq_flag(irq));
  gpc_psp_host i_gpc_psp_host (.clk_sys(clk_sys), .pd_drive(pd_drive), .pe_drive(pe_drive),
    .pd_level(pd_level), .pe_level(pe_level));
  assign pc_level = (pc_drive.enable & pc_drive.level) | (~pc_drive.enable & 8'h0f);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (irq === 1'b1)
      irq_n++;
    if (cycles == 3000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd_reg

  task automatic por;
    resetn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask : por

  initial
  begin
    {resetn, sys_reset, bus_req, periph_sel, periph_data, periph_oe} = '0;
    por();
    for (int i = 0; i < 12; i++)
    begin
      wr_reg(rows[i][0], rows[i][1]);
      repeat (6) @(posedge clk_sys);
      rd_reg(rows[i][0], v);
      chk(v, rows[i][2]);
    end
    $display("test table done");
    @(posedge clk_sys);
    periph_sel  <= 8'hf0;
    periph_data <= 8'ha0;
    periph_oe   <= 8'h30;
    repeat (3) @(posedge clk_sys);
    chk(pc_drive.enable, 8'h3f);
    chk(pc_drive.level, 8'ha6);
    periph_sel <= 8'h00;
    wr_reg(8'h9f, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk({5'h0, pe_drive.enable}, 8'h04);
    $display("test port c and e done");
    wr_reg(8'h9f, 8'h06);
    wr_reg(8'h89, 8'h17);
    wr_reg(8'h08, 8'h5a);
    rd_reg(8'h89, v);
    chk(v, 8'h57);
    i_gpc_psp_host.xfer(3'b010, 8'h00, v);
    chk(v, 8'h5a);
    rd_reg(8'h89, v);
    chk(v, 8'h17);
    i_gpc_psp_host.xfer(3'b101, 8'h11, v);
    rd_reg(8'h89, v);
    chk(v, 8'h17);
    i_gpc_psp_host.xfer(3'b001, 8'h3c, v);
    rd_reg(8'h89, v);
    chk(v, 8'h97);
    i_gpc_psp_host.xfer(3'b001, 8'h44, v);
    rd_reg(8'h89, v);
    chk(v, 8'hb7);
    rd_reg(8'h08, v);
    chk(v, 8'h44);
    rd_reg(8'h89, v);
    chk(v, 8'h37);
    wr_reg(8'h08, 8'ha5);
    wr_reg(8'h89, 8'h27);
    rd_reg(8'h89, v);
    chk(v, 8'h27);
    wr_reg(8'h89, 8'h07);
    rd_reg(8'h89, v);
    chk(v, 8'h07);
    chk(irq_n[7:0], 8'h03);
    $display("test slave port done");
    wr_reg(8'h87, 8'h00);
    @(posedge clk_sys);
    sys_reset <= 1'b1;
    @(posedge clk_sys);
    sys_reset <= 1'b0;
    rd_reg(8'h87, v);
    chk(v, 8'hff);
    wr_reg(8'h87, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk(pc_drive.level, 8'h96);
    por();
    rd_reg(8'h9f, v);
    chk(v, 8'h00);
    rd_reg(8'h09, v);
    chk(v, 8'h00);
    rd_reg(8'h89, v);
    chk(v, 8'h07);
    $display("test resets done");
    close_out();
  end
endmodule : test_gpc_ports
`default_nettype wire
